// >>> core/smbus_slave_pkg.sv
// Purpose: shared constants and types for the two-wire command slave port
// Assumes: 20 MHz system clock, serial clock supplied by the bus master
// Notes: strap pins arrive as two-bit level codes from the four-level sensors
`default_nettype none
package smbus_slave_pkg;
  localparam int unsigned REF_CLK_HZ = 20_000_000;
  localparam int unsigned TIMEOUT_MS = 28;
  // least time to declare a lockup, cycles per millisecond truncated to whole cycles
  localparam int unsigned TIMEOUT_CYCLES = (TIMEOUT_MS * (REF_CLK_HZ / 1000));
  localparam int TMO_W = 20;
  localparam logic [2:0] ADDR_PREFIX = 3'h4;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_VS = 2'h1;
  localparam logic [1:0] LVL_SDA = 2'h2;
  localparam logic [1:0] LVL_SCL = 2'h3;
  typedef logic [1:0] strap_t;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_IGNORE
  } link_state_e;
endpackage
`default_nettype wire

// >>> core/smbus_command_slave_port.sv
// Purpose: slave-only two-wire port with address straps, pointer and word access
// Assumes: scl_clk is the same wire as scl_in; sda is open drain, low when sda_oe is high
// Notes: bit sampling runs on scl_clk; framing, ack and timeout run on ref_clk
//
// How it works
// - sda falling while scl high starts a transaction; port detects it
// - sda rising while scl high ends a transaction; port detects it
// - address bits sampled on scl rising edges; last bit high means read
// - matching address acknowledged by pulling sda low in the ninth pulse
// - every byte is eight data bits plus one acknowledge bit
// - sda changes during scl high are framing events, not data
// - a 28 ms stall timeout keeps the bus from locking up
// - address byte is seven address bits msb first, then direction bit
// - own address is 100 then high strap bits 3:2 and low strap bits 1:0
// - strap levels are resampled at every transaction start
// - port never drives scl nor makes start or stop conditions
// - write data low byte first, read data high byte first
// - first byte after write address is the command, loaded into pointer
// - write word stores the two following bytes, each acknowledged
// - start or stop during a write abandons it
// - send byte ends after the acknowledged command
// - read word returns two bytes msb first after repeated start
// - master nack, start or stop ends a read; sda released
// - pointer kept until a later write changes it
// - read byte is read word ended after one byte
`default_nettype none
module smbus_command_slave_port #(
  parameter int unsigned TIMEOUT_LIMIT = smbus_slave_pkg::TIMEOUT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire smbus_slave_pkg::strap_t addr_select_low_pin,
  input wire smbus_slave_pkg::strap_t addr_select_high_pin,
  input wire smbus_slave_pkg::word_t rd_data,
  output smbus_slave_pkg::byte_t reg_ptr,
  output logic cmd_strobe,
  output logic wr_strobe,
  output smbus_slave_pkg::word_t wr_data,
  output logic rd_strobe,
  output logic busy,
  output logic timeout
);
  import smbus_slave_pkg::*;

  // link domain: capture sda at each scl rising edge and flag it by toggle
  logic link_bit_ff;
  logic link_tog_ff;
  always_ff @(posedge scl_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_bit_ff <= 1'b0;
      link_tog_ff <= 1'b0;
    end else begin
      link_bit_ff <= sda_in;
      link_tog_ff <= ~link_tog_ff;
    end
  end

  // pin and toggle synchronisers, plus a delayed copy for edge detection
  logic [1:0] scl_sync_ff, sda_sync_ff, tog_sync_ff;
  logic scl_prev_ff, sda_prev_ff, tog_prev_ff;
  strap_t lo_sync1_ff, lo_sync2_ff, hi_sync1_ff, hi_sync2_ff;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      tog_sync_ff <= 2'h0;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      tog_prev_ff <= 1'b0;
      lo_sync1_ff <= LVL_GND;
      lo_sync2_ff <= LVL_GND;
      hi_sync1_ff <= LVL_GND;
      hi_sync2_ff <= LVL_GND;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      tog_sync_ff <= {tog_sync_ff[0], link_tog_ff};
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
      tog_prev_ff <= tog_sync_ff[1];
      lo_sync1_ff <= addr_select_low_pin;
      lo_sync2_ff <= lo_sync1_ff;
      hi_sync1_ff <= addr_select_high_pin;
      hi_sync2_ff <= hi_sync1_ff;
    end
  end

  logic scl_hi, start_evt, stop_evt, bit_evt, scl_fall, bit_val;
  assign scl_hi = scl_sync_ff[1] & scl_prev_ff;
  // a data change while scl stays high is a framing condition
  assign start_evt = scl_hi & sda_prev_ff & ~sda_sync_ff[1];
  assign stop_evt = scl_hi & ~sda_prev_ff & sda_sync_ff[1];
  assign bit_evt = tog_sync_ff[1] ^ tog_prev_ff;
  assign scl_fall = scl_prev_ff & ~scl_sync_ff[1];
  // captured bit is stable for a whole scl period after its toggle
  assign bit_val = link_bit_ff;

  // stall timer: counts while a transfer is open and nothing moves
  logic [TMO_W-1:0] tmo_cnt_ff;
  logic tmo_hit;
  link_state_e state_ff;
  assign tmo_hit = (tmo_cnt_ff == TMO_W'(TIMEOUT_LIMIT - 1));
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state_ff == ST_IDLE || bit_evt || start_evt || scl_fall || tmo_hit) begin
      tmo_cnt_ff <= '0;
    end else begin
      tmo_cnt_ff <= tmo_cnt_ff + TMO_W'(1);
    end
  end

  // own address from the strap codes
  function automatic logic [6:0] own_addr(input strap_t hi, input strap_t lo);
    own_addr = {ADDR_PREFIX, hi, lo};
  endfunction

  // protocol state, bit count and shift registers
  logic [3:0] bit_cnt_ff;
  byte_t rx_sh_ff, tx_sh_ff, wr_lo_ff;
  logic [6:0] my_addr_ff;
  logic rd_hi_done_ff;
  logic wr_lo_done_ff;
  logic wr_hi_done_ff;
  byte_t rx_byte;
  logic bit_ok;
  assign rx_byte = {rx_sh_ff[6:0], bit_val};
  // a bit counts only when no framing event or timeout wins the same cycle
  assign bit_ok = bit_evt & ~start_evt & ~stop_evt & ~tmo_hit;

  // eighth data bit of a byte reached
  function automatic logic byte_end(input logic [3:0] cnt);
    byte_end = (cnt == LAST_BIT);
  endfunction

  // states in which the master shifts a byte in
  function automatic logic rx_state(input link_state_e st);
    rx_state = (st == ST_ADDR) || (st == ST_CMD) || (st == ST_WDATA);
  endfunction

  // states in which a byte is counted bit by bit
  function automatic logic count_state(input link_state_e st);
    count_state = rx_state(st) || (st == ST_RDATA);
  endfunction

  // transaction state: framing events first, then one step per captured bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
    end else if (start_evt) begin
      state_ff <= ST_ADDR;
    end else if (stop_evt || tmo_hit) begin
      state_ff <= ST_IDLE;
    end else if (bit_evt) begin
      case (state_ff)
        ST_ADDR: begin
          if (byte_end(bit_cnt_ff)) begin
            if (rx_byte[7:1] == my_addr_ff) begin
              state_ff <= ST_ADDR_ACK;
            end else begin
              state_ff <= ST_IGNORE;
            end
          end
        end
        ST_CMD: begin
          if (byte_end(bit_cnt_ff)) begin
            state_ff <= ST_CMD_ACK;
          end
        end
        ST_WDATA: begin
          if (byte_end(bit_cnt_ff)) begin
            if (wr_lo_done_ff && wr_hi_done_ff) begin
              state_ff <= ST_IGNORE; // third data byte is not acknowledged
            end else begin
              state_ff <= ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (rx_sh_ff[0]) begin
            state_ff <= ST_RDATA;
          end else begin
            state_ff <= ST_CMD;
          end
        end
        ST_CMD_ACK: begin
          state_ff <= ST_WDATA;
        end
        ST_WDATA_ACK: begin
          state_ff <= ST_WDATA;
        end
        ST_RDATA: begin
          if (byte_end(bit_cnt_ff)) begin
            state_ff <= ST_RACK;
          end
        end
        ST_RACK: begin
          if (bit_val) begin
            state_ff <= ST_IGNORE;
          end else begin
            state_ff <= ST_RDATA;
          end
        end
        ST_IDLE, ST_IGNORE: begin
          state_ff <= state_ff;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // bit position inside the byte; cleared by framing events and at each byte end
  always_ff @(posedge ref_clk) begin
    if (sys_rst || start_evt || stop_evt || tmo_hit) begin
      bit_cnt_ff <= '0;
    end else if (bit_evt) begin
      if (count_state(state_ff) && !byte_end(bit_cnt_ff)) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end else begin
        bit_cnt_ff <= '0;
      end
    end
  end

  // receive shifter, msb arrives first
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_sh_ff <= '0;
    end else if (bit_ok && rx_state(state_ff)) begin
      rx_sh_ff <= rx_byte;
    end
  end

  // transmit shifter: high byte at the read address ack, low byte at the first master ack
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_sh_ff <= IDLE_BYTE;
    end else if (bit_ok) begin
      case (state_ff)
        ST_ADDR_ACK: begin
          if (rx_sh_ff[0]) begin
            tx_sh_ff <= rd_data[15:8];
          end
        end
        ST_RDATA: begin
          tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
        end
        ST_RACK: begin
          if (!bit_val) begin
            tx_sh_ff <= rd_hi_done_ff ? IDLE_BYTE : rd_data[7:0];
          end
        end
        default: begin
          tx_sh_ff <= tx_sh_ff;
        end
      endcase
    end
  end

  // own address taken from the straps at every start
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      my_addr_ff <= own_addr(LVL_GND, LVL_GND);
    end else if (start_evt) begin
      my_addr_ff <= own_addr(hi_sync2_ff, lo_sync2_ff);
    end
  end

  // write word progress: first byte kept as low half, second marks the word done
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_lo_done_ff <= 1'b0;
      wr_hi_done_ff <= 1'b0;
      wr_lo_ff <= '0;
    end else if (start_evt) begin
      wr_lo_done_ff <= 1'b0;
      wr_hi_done_ff <= 1'b0;
    end else if (bit_ok && state_ff == ST_WDATA_ACK) begin
      if (!wr_lo_done_ff) begin
        wr_lo_ff <= rx_sh_ff;
        wr_lo_done_ff <= 1'b1;
      end else begin
        wr_hi_done_ff <= 1'b1;
      end
    end
  end

  // read progress: set once the high byte has been acknowledged
  always_ff @(posedge ref_clk) begin
    if (sys_rst || start_evt) begin
      rd_hi_done_ff <= 1'b0;
    end else if (bit_ok && state_ff == ST_RACK && !bit_val) begin
      rd_hi_done_ff <= 1'b1;
    end
  end

  // sda drive changes only after scl falls; released at once on any framing event or timeout
  always_ff @(posedge ref_clk) begin
    if (sys_rst || start_evt || stop_evt || tmo_hit) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      case (state_ff)
        ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK: sda_oe <= 1'b1;
        ST_RDATA: sda_oe <= ~tx_sh_ff[7];
        default: sda_oe <= 1'b0;
      endcase
    end
  end
  // open drain: only ever pulls low, scl is never driven
  assign sda_out = 1'b0;

  // pointer loaded when the command byte's ack bit is seen
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_ptr <= '0;
    end else if (bit_ok && state_ff == ST_CMD_ACK) begin
      reg_ptr <= rx_sh_ff;
    end
  end

  // one-cycle pulse per acknowledged command
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cmd_strobe <= 1'b0;
    end else begin
      cmd_strobe <= bit_ok && (state_ff == ST_CMD_ACK);
    end
  end

  // word handed over once its second byte is acknowledged
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_data <= '0;
      wr_strobe <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      if (bit_ok && state_ff == ST_WDATA_ACK && wr_lo_done_ff) begin
        wr_data <= {rx_sh_ff, wr_lo_ff};
        wr_strobe <= 1'b1;
      end
    end
  end

  // read pulse when a read address is acknowledged
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_strobe <= 1'b0;
    end else begin
      rd_strobe <= bit_ok && (state_ff == ST_ADDR_ACK) && rx_sh_ff[0];
    end
  end

  // transfer open flag
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_ff != ST_IDLE);
    end
  end

  // one-cycle pulse when the stall timer fires and no start wins the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timeout <= 1'b0;
    end else begin
      timeout <= tmo_hit && !start_evt;
    end
  end
endmodule
`default_nettype wire

// >>> dv/smbus_port_checker.sv
// Purpose: port checks of the two-wire slave
// Assumes: scl_in and sda_in are bus levels
// Notes: slack of 8 cycles covers the synchronisers
`default_nettype none
module smbus_port_checker #(
  parameter int unsigned TIMEOUT_LIMIT = 2000
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire smbus_slave_pkg::byte_t reg_ptr,
  input wire logic busy,
  input wire logic timeout
);
  import smbus_slave_pkg::*;
  int unsigned stall_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // cycles with scl still while a transfer is open
  always_ff @(posedge ref_clk) begin
    stall_ff <= (sys_rst || !busy || $changed(scl_in)) ? 0 : stall_ff + 1;
  end
  a_drive_low: assert property (sda_out == 1'b0) else $error("sda driven high");
  a_oe_scl_low: assert property ($rose(sda_oe) |-> !scl_in) else $error("pull at scl high");
  a_ptr_kept: assert property ($changed(reg_ptr) |-> busy) else $error("pointer moved");
  a_tmo_release: assert property (timeout |=> !sda_oe && !busy) else $error("bus kept");
  a_start_seen: assert property (!busy && scl_in && $fell(sda_in) |-> ##[1:6] busy) else $error("no start");
  a_stop_seen: assert property (busy && scl_in && $rose(sda_in) |-> ##[1:6] !busy) else $error("no stop");
  a_tmo_early: assert property (timeout |-> stall_ff + 8 >= TIMEOUT_LIMIT) else $error("timeout early");
  a_tmo_late: assert property (stall_ff <= TIMEOUT_LIMIT + 8) else $error("timeout late");
endmodule
`default_nettype wire

// >>> dv/smbus_master_model.sv
// Purpose: bus master driving scl and its side of sda
// Assumes: sda is the resolved wire with a pull-up
// Notes: scl stands still between frames
`default_nettype none
module smbus_master_model #(
  parameter int HALF_NS = 650
) (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  import smbus_slave_pkg::*;
  // bus idle with both lines released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // start or repeated start, leaves scl low
  task automatic start_cond();
    sda_drv = 1'b1;
    #HALF_NS;
    scl = 1'b1;
    #HALF_NS;
    sda_drv = 1'b0;
    #HALF_NS;
    scl = 1'b0;
    #HALF_NS;
  endtask
  // stop from scl low
  task automatic stop_cond();
    sda_drv = 1'b0;
    #HALF_NS;
    scl = 1'b1;
    #HALF_NS;
    sda_drv = 1'b1;
    #HALF_NS;
  endtask
  // one pulse, data changed only while scl is low
  task automatic one_bit(input logic b, output logic r);
    sda_drv = b;
    #HALF_NS;
    scl = 1'b1;
    #HALF_NS;
    r = sda;
    scl = 1'b0;
    #HALF_NS;
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic xfer(input byte_t d, input logic ack_in, output byte_t r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      one_bit(d[i], r[i]);
    end
    one_bit(ack_in, ack);
  endtask
endmodule
`default_nettype wire

// >>> dv/smbus_command_slave_port_test.sv
// Purpose: self-checking bench of the two-wire command slave port
// Assumes: pull-up on sda; rd_data mirrors the pointer
// Notes: lockup timer shortened to TMO cycles
`default_nettype none
module smbus_command_slave_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import smbus_slave_pkg::*;
  localparam int TMO = 2000;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b0;
  logic scl, sda_drv, sda, sda_out, sda_oe, cmd_strobe, wr_strobe, rd_strobe, busy, timeout;
  strap_t addr_select_low_pin = 2'h0;
  strap_t addr_select_high_pin = 2'h0;
  word_t rd_data = 16'h0;
  word_t wr_data;
  byte_t reg_ptr;
  logic [6:0] own;
  int err_count = 0;
  int num_checks = 0;
  int n_wr = 0;
  int n_cmd = 0;
  int n_tmo = 0;
  int n_rd = 0;
  smbus_master_model host (.scl, .sda_drv, .sda);
  smbus_command_slave_port #(.TIMEOUT_LIMIT(TMO)) smbus_command_slave_port_inst (.ref_clk, .sys_rst,
    .scl_clk(scl), .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .addr_select_low_pin, .addr_select_high_pin,
    .rd_data, .reg_ptr, .cmd_strobe, .wr_strobe, .wr_data, .rd_strobe, .busy, .timeout);
  always #25 ref_clk = ~ref_clk;
  // open-drain wire and own address from the straps
  assign sda = sda_drv & ~sda_oe;
  assign own = {ADDR_PREFIX, addr_select_high_pin, addr_select_low_pin};
  // user side: read word mirrors the pointer, pulses counted
  always @(negedge ref_clk) rd_data <= {reg_ptr, ~reg_ptr};
  always @(posedge ref_clk) begin
    if (!sys_rst) begin
      n_wr <= n_wr + wr_strobe;
      n_cmd <= n_cmd + cmd_strobe;
      n_tmo <= n_tmo + timeout;
      n_rd <= n_rd + rd_strobe;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one byte from the host, acknowledge compared
  task automatic wb(input byte_t d, input logic ack);
    byte_t r;
    logic a;
    host.xfer(d, 1'b1, r, a);
    check(a, ack);
  endtask
  // one byte to the host, data compared
  task automatic rb(input byte_t exp, input logic nack);
    byte_t r;
    logic a;
    host.xfer(8'hff, nack, r, a);
    check(r, exp);
  endtask
  task automatic head(input byte_t cmd);
    host.start_cond();
    wb({own, 1'b0}, 1'b0);
    wb(cmd, 1'b0);
  endtask
  // every strap pair, a near-miss address first
  task automatic t_addr_all();
    for (int k = 0; k < 16; k++) begin
      @(negedge ref_clk);
      {addr_select_high_pin, addr_select_low_pin} = k[3:0];
      host.start_cond();
      wb({own ^ (7'h01 << (k % 7)), 1'b0}, 1'b1);
      host.start_cond();
      wb({own, 1'b0}, 1'b0);
      host.stop_cond();
    end
  endtask
  task automatic t_write(input byte_t ptr, input word_t w);
    int n0;
    n0 = n_wr;
    head(ptr);
    wb(w[7:0], 1'b0);
    wb(w[15:8], 1'b0);
    host.stop_cond();
    check(n_wr, n0 + 1);
    check(wr_data, w);
    check(reg_ptr, ptr);
  endtask
  // send byte, then a write cut short after one data byte
  task automatic t_send_abort(input byte_t ptr);
    int c0, w0;
    c0 = n_cmd;
    w0 = n_wr;
    head(ptr);
    host.stop_cond();
    check(n_cmd, c0 + 1);
    head(ptr);
    wb(8'h5a, 1'b0);
    host.stop_cond();
    check(n_wr, w0);
  endtask
  task automatic t_read(input byte_t ptr, input logic two, input logic cmd);
    int r0;
    r0 = n_rd;
    if (cmd) head(ptr);
    host.start_cond();
    wb({own, 1'b1}, 1'b0);
    rb(ptr, !two);
    if (two) rb(~ptr, 1'b1);
    host.stop_cond();
    check(sda, 1'b1);
    check(n_rd, r0 + 1);
  endtask
  // address ack held with scl stopped until the lockup timer fires
  task automatic t_stall();
    byte_t b;
    logic a;
    b = {own, 1'b1};
    host.start_cond();
    for (int i = 7; i >= 0; i--) begin
      host.one_bit(b[i], a);
    end
    repeat (TMO - 50) @(posedge ref_clk);
    check(n_tmo, 0);
    repeat (100) @(posedge ref_clk);
    check(n_tmo, 1);
    check({busy, sda}, 2'h1);
    host.stop_cond();
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    // a real rising edge of reset, so the link flops clear too
    @(negedge ref_clk);
    sys_rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_addr_all();
    t_write(8'h4a, 16'h1234);
    t_read(8'h4a, 1'b1, 1'b1);
    t_read(8'h4a, 1'b0, 1'b0);
    t_send_abort(8'h03);
    t_stall();
    summarize();
  end
  // watchdog
  initial begin
    #3_000_000;
    err_count++;
    summarize();
  end
endmodule
bind smbus_command_slave_port smbus_port_checker #(.TIMEOUT_LIMIT(TIMEOUT_LIMIT)) smbus_port_checker_inst (
  .ref_clk, .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe, .reg_ptr, .busy, .timeout);
`default_nettype wire
